/* design/fad_datapath.sv */
// Fixed-point, floating-point and logical arithmetic datapath with eight
// floating-point registers, driven by commands written over APB.
// Assumes an APB master on pclk; operands and results pass through registers.
`timescale 1ns/1ps
`include "fad_params.svh"

// Operation
// - Halfwords are the basic fixed operand; multiply and divide use fullwords.
// - Fixed values are signed two's complement, 15 or 31 magnitude bits.
// - Fixed zero is always encoded with every bit cleared.
// - Float is sign bit, seven-bit exponent, then six hex fraction digits.
// - Float uses sign and magnitude; sign set means negative.
// - Stored exponent is true exponent plus 64.
// - Value is fraction times sixteen to the true exponent.
// - Operands used as given; every nonzero result is post-normalised.
// - Float load normalises its source before writing the register.
// - Overflow above exponent 63, underflow below exponent -64.
// - Overflow flag set on either exponent overflow or underflow.
// - Greater on positive overflow, less on negative, both clear on underflow.
// - Overflow forces exponent and fraction to ones, keeping sign.
// - Underflow forces the whole result to true zero.
// - Zero fraction after significance loss gives true zero; zeros compute normally.
// - Eight separate 32-bit float registers, even numbers 0 to 14.
// - Logical operations use 8, 16 or 32 bits, all bits taking part.
// - Halfword results are 16 bits wide, with the upper half of the result word cleared.
// - Enabled float fault on exponent exceptions, with the forced result still written, or on zero divide, before write.
// - Enabled fixed divide fault on zero divisor or quotient overflow, before write.
module fad_datapath
	import fad_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Arithmetic fault pulses toward the interrupt logic.
	output logic                   fxdiv_fault,
	output logic                   flt_fault
);
	import fad_pkg::*;

	// -------------------------------------------------------------------------
	// Elaboration check.
	// -------------------------------------------------------------------------
	generate
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("fad_datapath: ADDR_W must lie between 8 and 32");
		end
	endgenerate

	// -------------------------------------------------------------------------
	// State.
	// -------------------------------------------------------------------------
	logic [31:0]          opa_q;
	logic [31:0]          opb_q;
	logic [`FAD_CMD_W-1:0] cmd_q;
	logic [15:0]          program_status_word_q;
	logic [31:0]          result_q;
	logic [5:0]           status_q;
	logic                 go_q;
	logic [31:0]          fpr_q [0:7];
	logic                 fxdiv_fault_q;
	logic                 flt_fault_q;

	// -------------------------------------------------------------------------
	// APB decode. The slave never waits, so pready is tied high in access.
	// -------------------------------------------------------------------------
	wire       acc      = psel & penable;
	wire       wr_en    = acc & pwrite;
	wire [7:0] addr8    = paddr[7:0];
	wire       hi_zero  = (ADDR_W > 8) ? (paddr >> 8) == '0 : 1'b1;
	wire       sel_opa  = hi_zero && addr8 == `FAD_OFF_OPA;
	wire       sel_opb  = hi_zero && addr8 == `FAD_OFF_OPB;
	wire       sel_cmd  = hi_zero && addr8 == `FAD_OFF_CMD;
	wire       sel_pword = hi_zero && addr8 == `FAD_OFF_PROG_WORD;
	wire       sel_res  = hi_zero && addr8 == `FAD_OFF_RESULT;
	wire       sel_sta  = hi_zero && addr8 == `FAD_OFF_STATUS;
	wire       mapped   = sel_opa | sel_opb | sel_cmd | sel_pword | sel_res | sel_sta;

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;
	assign prdata  = !(acc && !pwrite) ? 32'h0000_0000 :
	                 sel_opa ? opa_q :
	                 sel_opb ? opb_q :
	                 sel_cmd ? {{(32-`FAD_CMD_W){1'b0}}, cmd_q} :
	                 sel_pword ? {16'h0000, program_status_word_q} :
	                 sel_res ? result_q :
	                 sel_sta ? {26'h000_0000, status_q} : 32'h0000_0000;
	assign fxdiv_fault = fxdiv_fault_q;
	assign flt_fault   = flt_fault_q;

	// -------------------------------------------------------------------------
	// Command fields. Register numbers are even; the low bit is ignored.
	// -------------------------------------------------------------------------
	wire fad_op_e  op     = fad_op_e'(cmd_q[`FAD_CMD_OP_LSB +: 4]);
	wire [2:0]     r1_idx = cmd_q[`FAD_CMD_R1_LSB+1 +: 3];
	wire [2:0]     r2_idx = cmd_q[`FAD_CMD_R2_LSB+1 +: 3];
	wire fad_wid_e wid    = fad_wid_e'(cmd_q[`FAD_CMD_WID_LSB +: 2]);
	wire           srcf   = cmd_q[`FAD_CMD_SRCF_BIT];

	// Fault enables taken from the program status word.
	wire fxdiv_en = program_status_word_q[`FAD_PROG_WORD_FXDIV_IDX];
	wire flt_en   = program_status_word_q[`FAD_PROG_WORD_FLT_IDX];

	// -------------------------------------------------------------------------
	// Float operands: first from a float register, second from a register or
	// from the operand word standing in for memory.
	// -------------------------------------------------------------------------
	wire [31:0] fa_w = fpr_q[r1_idx];
	wire [31:0] fb_w = srcf ? fpr_q[r2_idx] : opa_q;

	// Unpack a stored exponent into a signed true exponent.
	function automatic logic signed [9:0] fp_exp(input logic [31:0] w);
		fp_exp = $signed({3'b000, w[30:24]}) - `FAD_EXP_BIAS;
	endfunction

	// Normalise a fraction 0.f (eight hex digits) times 16^e and pack it,
	// detecting exponent overflow and underflow on the normalised exponent.
	function automatic fad_fpres_s fp_pack(input logic s, input logic signed [9:0] e,
	                                       input logic [31:0] f);
		logic [31:0]        m;
		logic signed [9:0]  x;
		fad_fpres_s         r;
		m = f;
		x = e;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			if (m[31:28] == 4'h0 && m != 32'h0) begin
				m = {m[27:0], 4'h0};
				x = x - 10'sd1;
			end
		end
		if (m[31:8] == 24'h00_0000) begin
			r.word = 32'h0000_0000;
		end else if (x > `FAD_EXP_MAX) begin
			r.ovf  = 1'b1;
			r.word = {s, `FAD_FP_OVF_MAG};
		end else if (x < `FAD_EXP_MIN) begin
			r.unf  = 1'b1;
			r.word = 32'h0000_0000;
		end else begin
			r.word = {s, 7'(x + `FAD_EXP_BIAS), m[31:8]};
		end
		return r;
	endfunction

	// -------------------------------------------------------------------------
	// Float add and subtract: align the smaller exponent by whole hex digits,
	// two guard digits kept, then add or subtract magnitudes.
	// -------------------------------------------------------------------------
	wire signed [9:0] ea = fp_exp(fa_w);
	wire signed [9:0] eb = fp_exp(fb_w);
	wire              sb_eff = fb_w[31] ^ (op == FAD_OP_FSUB);
	wire              swp    = eb > ea;
	wire signed [9:0] xl     = swp ? eb : ea;
	wire signed [9:0] dexp   = swp ? (eb - ea) : (ea - eb);
	wire [31:0]       fl     = swp ? {fb_w[23:0], 8'h00} : {fa_w[23:0], 8'h00};
	wire [31:0]       fs     = swp ? {fa_w[23:0], 8'h00} : {fb_w[23:0], 8'h00};
	wire              sl     = swp ? sb_eff : fa_w[31];
	wire              ss     = swp ? fa_w[31] : sb_eff;
	wire [31:0]       fsa    = (dexp > 10'sd7) ? 32'h0000_0000 : fs >> {dexp[2:0], 2'b00};
	wire [32:0]       fsum   = {1'b0, fl} + {1'b0, fsa};
	wire              mag_ge = fl >= fsa;
	logic [31:0]      add_f;
	logic             add_s;
	logic signed [9:0] add_x;

	// Carry out of the top digit shifts right one digit and bumps the exponent.
	always_comb begin
		add_x = xl;
		if (sl == ss) begin
			add_s = sl;
			if (fsum[32]) begin
				add_f = fsum[32:1] >> 3;
				add_x = xl + 10'sd1;
			end else begin
				add_f = fsum[31:0];
			end
		end else if (mag_ge) begin
			add_s = sl;
			add_f = fl - fsa;
		end else begin
			add_s = ss;
			add_f = fsa - fl;
		end
	end

	// -------------------------------------------------------------------------
	// Float multiply and divide on the 24-bit fractions.
	// -------------------------------------------------------------------------
	wire [47:0] fprod  = 48'(fa_w[23:0]) * 48'(fb_w[23:0]);
	wire        fb_zf  = fb_w[23:0] == 24'h00_0000;
	wire [55:0] fquo   = {fa_w[23:0], 32'h0000_0000} / {32'h0000_0000, fb_zf ? 24'h00_0001 :
	                      fb_w[23:0]};
	wire [31:0] div_f  = (fquo[35:32] != 4'h0) ? fquo[35:4] : fquo[31:0];
	wire signed [9:0] div_x = ea - eb + ((fquo[35:32] != 4'h0) ? 10'sd1 : 10'sd0);
	wire        fsgn   = fa_w[31] ^ fb_w[31];

	// -------------------------------------------------------------------------
	// Fixed-point halfword, multiply and divide arithmetic.
	// -------------------------------------------------------------------------
	wire [15:0]        ha    = opa_q[15:0];
	wire [15:0]        hb    = opb_q[15:0];
	wire [16:0]        hsum  = (op == FAD_OP_HSUB) ? {ha[15], ha} - {hb[15], hb} :
	                                                 {ha[15], ha} + {hb[15], hb};
	wire               h_ovf = hsum[16] != hsum[15];
	wire signed [31:0] mprod = $signed(ha) * $signed(hb);
	wire signed [32:0] dvd   = $signed({opa_q[31], opa_q});
	wire signed [32:0] dvs   = $signed({{17{hb[15]}}, hb});
	wire               dz    = hb == 16'h0000;
	wire signed [32:0] dvs_s = dz ? 33'sd1 : dvs;
	wire signed [32:0] quo   = dvd / dvs_s;
	wire signed [32:0] rem   = dvd % dvs_s;
	wire               q_ovf = quo > `FAD_HALF_MAX || quo < `FAD_HALF_MIN;

	// Logical operand mask.
	wire [31:0] lmask = (wid == FAD_W_BYTE) ? `FAD_MASK_BYTE :
	                    (wid == FAD_W_HALF) ? `FAD_MASK_HALF : `FAD_MASK_FULL;
	wire        lsign = (wid == FAD_W_BYTE) ? 1'b0 : 1'b0;

	// -------------------------------------------------------------------------
	// Result selection. Faults that must precede any register change leave
	// the write enables low, so the float and result registers keep their value.
	// -------------------------------------------------------------------------
	fad_fpres_s  fp_r;
	logic [31:0] res_d;
	logic        ovf_d;
	logic        neg_d;
	logic        wr_res;
	logic        wr_fpr;
	logic        fx_flt;
	logic        fl_flt;
	logic        is_fp;

	always_comb begin
		fp_r   = '0;
		res_d  = 32'h0000_0000;
		ovf_d  = 1'b0;
		neg_d  = 1'b0;
		wr_res = 1'b1;
		wr_fpr = 1'b0;
		fx_flt = 1'b0;
		fl_flt = 1'b0;
		is_fp  = 1'b0;
		case (op)
			FAD_OP_HADD, FAD_OP_HSUB: begin
				res_d = {16'h0000, hsum[15:0]};
				ovf_d = h_ovf;
				neg_d = hsum[15];
			end
			FAD_OP_MUL: begin
				res_d = mprod;
				neg_d = mprod[31];
			end
			FAD_OP_DIV: begin
				if (dz || q_ovf) begin
					fx_flt = 1'b1;
					wr_res = 1'b0;
				end else begin
					res_d = {rem[15:0], quo[15:0]};
					neg_d = quo[15];
				end
			end
			FAD_OP_AND, FAD_OP_OR, FAD_OP_XOR: begin
				res_d = (op == FAD_OP_AND) ? (opa_q & opb_q) & lmask :
				        (op == FAD_OP_OR)  ? (opa_q | opb_q) & lmask :
				                             (opa_q ^ opb_q) & lmask;
				neg_d = lsign;
			end
			FAD_OP_FLOAD: begin
				is_fp  = 1'b1;
				fp_r   = fp_pack(fb_w[31], eb, {fb_w[23:0], 8'h00});
				wr_fpr = 1'b1;
			end
			FAD_OP_FSTOR: begin
				res_d = fa_w;
				neg_d = fa_w[31] && fa_w[30:0] != 31'h0;
			end
			FAD_OP_FADD, FAD_OP_FSUB: begin
				is_fp  = 1'b1;
				fp_r   = fp_pack(add_s, add_x, add_f);
				wr_fpr = 1'b1;
			end
			FAD_OP_FMUL: begin
				is_fp  = 1'b1;
				fp_r   = fp_pack(fsgn, ea + eb, fprod[47:16]);
				wr_fpr = 1'b1;
			end
			FAD_OP_FDIV: begin
				if (fb_zf) begin
					fl_flt = 1'b1;
					wr_res = 1'b0;
				end else begin
					is_fp  = 1'b1;
					fp_r   = fp_pack(fsgn, div_x, div_f);
					wr_fpr = 1'b1;
				end
			end
			default: begin
				wr_res = 1'b0;
			end
		endcase
		if (is_fp) begin
			res_d  = fp_r.word;
			ovf_d  = fp_r.ovf | fp_r.unf;
			neg_d  = fp_r.word[31];
			fl_flt = fp_r.ovf | fp_r.unf;
		end
	end

	// Greater and less follow the sign of a nonzero result, logical results counting as positive; after an exponent
	// underflow the true zero clears both, after overflow the sign chooses.
	wire res_nz = (op == FAD_OP_HADD || op == FAD_OP_HSUB) ? res_d[15:0] != 16'h0000 :
	              is_fp ? res_d[30:0] != 31'h0 : res_d != 32'h0000_0000;
	wire gt_d   = res_nz & ~neg_d;
	wire lt_d   = res_nz & neg_d;

	// -------------------------------------------------------------------------
	// Register writes from the bus.
	// -------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa_q <= 32'h0000_0000;
			opb_q <= 32'h0000_0000;
			cmd_q <= '0;
			program_status_word_q <= `FAD_PROG_WORD_RESET;
			go_q  <= 1'b0;
		end else begin
			go_q <= wr_en & sel_cmd;
			if (wr_en && sel_opa) begin
				opa_q <= pwdata;
			end
			if (wr_en && sel_opb) begin
				opb_q <= pwdata;
			end
			if (wr_en && sel_cmd) begin
				cmd_q <= pwdata[`FAD_CMD_W-1:0];
			end
			if (wr_en && sel_pword) begin
				program_status_word_q <= pwdata[15:0];
			end
		end
	end

	// -------------------------------------------------------------------------
	// Execution, one cycle after the command write. A zero divide or fixed
	// quotient overflow leaves the result and status flags untouched but records the fault.
	// -------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_q      <= 32'h0000_0000;
			status_q      <= 6'h00;
			fxdiv_fault_q <= 1'b0;
			flt_fault_q   <= 1'b0;
		end else begin
			fxdiv_fault_q <= go_q & fx_flt & fxdiv_en;
			flt_fault_q   <= go_q & fl_flt & flt_en;
			status_q[`FAD_ST_BUSY] <= wr_en & sel_cmd;
			if (go_q) begin
				status_q[`FAD_ST_FXDIV] <= fx_flt;
				status_q[`FAD_ST_FLT]   <= fl_flt;
			end
			if (go_q && wr_res) begin
				result_q              <= res_d;
				status_q[`FAD_ST_OVF] <= ovf_d;
				status_q[`FAD_ST_GT]  <= gt_d;
				status_q[`FAD_ST_LT]  <= lt_d;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Float registers, reachable only through float commands.
	// -------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) begin
				fpr_q[i] <= 32'h0000_0000;
			end
		end else if (go_q && wr_fpr) begin
			fpr_q[r1_idx] <= fp_r.word;
		end
	end

endmodule

/* design/fad_params.svh */
// Constants of the fixed and floating arithmetic datapath: register offsets,
// command fields, status bits and number-format fields.
// Assumes inclusion by bare name from the datapath module.
`ifndef FAD_PARAMS_SVH
`define FAD_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each).
// -----------------------------------------------------------------------------
`define FAD_OFF_OPA        8'h00
`define FAD_OFF_OPB        8'h04
`define FAD_OFF_CMD        8'h08
`define FAD_OFF_PROG_WORD  8'h0C
`define FAD_OFF_RESULT     8'h10
`define FAD_OFF_STATUS     8'h14

// -----------------------------------------------------------------------------
// Command register fields.
// -----------------------------------------------------------------------------
`define FAD_CMD_OP_LSB     0
`define FAD_CMD_R1_LSB     4
`define FAD_CMD_R2_LSB     8
`define FAD_CMD_WID_LSB    12
`define FAD_CMD_SRCF_BIT   14
`define FAD_CMD_W          15

// -----------------------------------------------------------------------------
// Program status word: bit n counted from the left sits at index 15 - n.
// -----------------------------------------------------------------------------
`define FAD_PROG_WORD_RESET      16'h0000
`define FAD_PROG_WORD_FXDIV_IDX  12
`define FAD_PROG_WORD_FLT_IDX    10

// -----------------------------------------------------------------------------
// Status register bits.
// -----------------------------------------------------------------------------
`define FAD_ST_OVF         0
`define FAD_ST_GT          1
`define FAD_ST_LT          2
`define FAD_ST_FXDIV       3
`define FAD_ST_FLT         4
`define FAD_ST_BUSY        5

// -----------------------------------------------------------------------------
// Number formats.
// -----------------------------------------------------------------------------
`define FAD_EXP_BIAS       10'sd64
`define FAD_EXP_MAX        10'sd63
`define FAD_EXP_MIN        -10'sd64
`define FAD_HALF_MAX       33'sd32767
`define FAD_HALF_MIN       -33'sd32768
`define FAD_MASK_BYTE      32'h0000_00FF
`define FAD_MASK_HALF      32'h0000_FFFF
`define FAD_MASK_FULL      32'hFFFF_FFFF
`define FAD_FP_OVF_MAG     31'h7FFF_FFFF

`endif

/* design/fad_pkg.sv */
// Types shared by the arithmetic datapath and its bench: operation codes,
// logical operand widths and the packed floating-point result.
// Assumes the constants header sits beside it.
package fad_pkg;

	// -------------------------------------------------------------------------
	// Operation codes written into the command register.
	// -------------------------------------------------------------------------
	typedef enum logic [3:0] {
		FAD_OP_HADD  = 4'h0,
		FAD_OP_HSUB  = 4'h1,
		FAD_OP_MUL   = 4'h2,
		FAD_OP_DIV   = 4'h3,
		FAD_OP_AND   = 4'h4,
		FAD_OP_OR    = 4'h5,
		FAD_OP_XOR   = 4'h6,
		FAD_OP_FLOAD = 4'h7,
		FAD_OP_FSTOR = 4'h8,
		FAD_OP_FADD  = 4'h9,
		FAD_OP_FSUB  = 4'hA,
		FAD_OP_FMUL  = 4'hB,
		FAD_OP_FDIV  = 4'hC
	} fad_op_e;

	// Logical operand width selector.
	typedef enum logic [1:0] {
		FAD_W_BYTE = 2'h0,
		FAD_W_HALF = 2'h1,
		FAD_W_FULL = 2'h2
	} fad_wid_e;

	// A packed floating-point result with its exponent exceptions.
	typedef struct packed {
		logic [31:0] word;
		logic        ovf;
		logic        unf;
	} fad_fpres_s;

endpackage

/* test/fad_datapath_properties.sv */
// Checker for the arithmetic datapath, seeing only its APB and fault ports.
// Assumes the bind at the foot attaches it to every datapath instance.
`timescale 1ns/1ps
module fad_datapath_chk #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input wire logic              pclk,
	input wire logic              presetn,
	// APB slave.
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Fault pulses.
	input wire logic              fxdiv_fault,
	input wire logic              flt_fault
);
	// -------------------------------------------------------------------------
	// Shadows of the operands and status word, so causes can be seen.
	// -------------------------------------------------------------------------
	logic [31:0] opa_q;
	logic [31:0] opb_q;
	logic [31:0] pword_q;
	wire         wr     = psel && penable && pready && pwrite;
	wire         cmd_wr = wr && paddr == ADDR_W'(8'h08);

	// Shadows follow accepted writes only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa_q <= 32'h0;
			opb_q <= 32'h0;
			pword_q <= 32'h0;
		end else if (wr) begin
			if (paddr == ADDR_W'(8'h00)) opa_q <= pwdata;
			if (paddr == ADDR_W'(8'h04)) opb_q <= pwdata;
			if (paddr == ADDR_W'(8'h0C)) pword_q <= pwdata;
		end
	end

	// -------------------------------------------------------------------------
	// Properties.
	// -------------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	fx_pulse_a: assert property (fxdiv_fault |=> !fxdiv_fault)
		else $error("fixed divide fault longer than one cycle");
	fx_enable_a: assert property (fxdiv_fault |-> pword_q[12])
		else $error("fixed divide fault while disabled");
	fx_cause_a: assert property (fxdiv_fault |-> $past(cmd_wr && pwdata[3:0] == 4'h3, 2))
		else $error("fixed divide fault without a divide command");
	fx_zero_a: assert property (cmd_wr && pwdata[3:0] == 4'h3 && opb_q[15:0] == 16'h0
		&& pword_q[12] |-> ##2 fxdiv_fault) else $error("zero divisor gave no fault");
	fl_pulse_a: assert property (flt_fault |=> !flt_fault)
		else $error("float fault longer than one cycle");
	fl_enable_a: assert property (flt_fault |-> pword_q[10])
		else $error("float fault while disabled");
	fl_cause_a: assert property (flt_fault |-> $past(cmd_wr && pwdata[3:0] inside {4'h7,
		[4'h9:4'hC]}, 2)) else $error("float fault without a float command");
	fl_zero_a: assert property (cmd_wr && pwdata[3:0] == 4'hC && !pwdata[14]
		&& opa_q[23:0] == 24'h0 && pword_q[10] |-> ##2 flt_fault)
		else $error("float zero divisor gave no fault");
	flag_excl_a: assert property (psel && penable && !pwrite && paddr == ADDR_W'(8'h14)
		|-> !(prdata[1] && prdata[2])) else $error("greater and less both set");
	slverr_map_a: assert property (psel && penable |-> pslverr == (paddr[1:0] != 2'h0
		|| paddr > ADDR_W'(8'h14))) else $error("error response does not follow the map");

	cover property (fxdiv_fault);
	cover property (flt_fault);
	cover property (pslverr);
endmodule

bind fad_datapath fad_datapath_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .fxdiv_fault(fxdiv_fault),
	.flt_fault(flt_fault));

/* test/fad_seq_model.sv */
// Sequencer model: issues APB transfers toward the datapath on request.
// Assumes callers enter its task just after a rising pclk edge.
`timescale 1ns/1ps
module fad_seq_model (
	// Clock.
	input  wire logic        pclk,
	// APB master side.
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready
);
	// Idle bus at time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// One transfer; the request stands until pready is seen high.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // Released data flips so stale values never look valid.
		@(posedge pclk);
	endtask
endmodule

/* test/fad_datapath_bench.sv */
// Self-checking bench for the arithmetic datapath.
// Assumes the sequencer model drives APB; a monitor compares each read.
`timescale 1ns/1ps
module fad_datapath_bench;
	import fad_pkg::*;
	logic        pclk;
	logic        presetn;
	wire         psel;
	wire         penable;
	wire         pwrite;
	wire  [7:0]  paddr;
	wire  [31:0] pwdata;
	wire  [31:0] prdata;
	wire         pready;
	int          error_cnt;
	int          tests_run;
	int          seed;
	int          cyc;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [31:0] fl_l[5] = '{32'h7F100000, 32'h7F100000, 32'h00100000, 32'h41100000, 32'h41100000};
	logic [31:0] fl_a[5] = '{32'h7F100000, 32'hFF100000, 32'h00100000, 32'hC1100000, 32'h0};
	logic [31:0] fl_e[5] = '{32'h7FFFFFFF, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h41100000};
	logic [31:0] fl_s[5] = '{32'h13, 32'h15, 32'h11, 32'h0, 32'h12};
	fad_op_e     fl_o[5] = '{FAD_OP_FMUL, FAD_OP_FMUL, FAD_OP_FMUL, FAD_OP_FADD, FAD_OP_FDIV};

	fad_seq_model m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready));
	fad_datapath dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(), .fxdiv_fault(), .flt_fault());

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	function automatic logic [31:0] cm(input fad_op_e op, input logic [3:0] r1, input logic [1:0] w);
		return {18'h0, w, 4'h0, r1, op};
	endfunction

	// Operands first, then the command that consumes them.
	task automatic run(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		m.xfer(1'b1, 8'h00, a);
		m.xfer(1'b1, 8'h04, b);
		m.xfer(1'b1, 8'h08, c);
	endtask

	// The expectation is noted before the read is issued.
	task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
		exp_q.push_back(e);
		msk_q.push_back(k);
		m.xfer(1'b0, a, 32'h0);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Monitor: each read result is held against the oldest note; a hang ends the run.
	always @(posedge pclk) begin
		cyc++;
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			tests_run++;
			if ((prdata & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
				error_cnt++;
				$display("mismatch reg %h expected %h seen %h", paddr, exp_q[0], prdata);
			end
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
		if (cyc > 6000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		logic [15:0] a;
		logic [15:0] b;
		logic [16:0] s;
		logic [31:0] ra;
		logic [31:0] rb;
		logic [31:0] e;
		presetn = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		seed = 57846;
		cyc = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(8'h14, 32'h0, 32'hFFFFFFFF);
		chk(8'h18, 32'h0, 32'hFFFFFFFF);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 16'h7FFF : 16'($random(seed));
			b = (i == 0) ? 16'h0001 : 16'($random(seed));
			s = i[0] ? {a[15], a} - {b[15], b} : {a[15], a} + {b[15], b};
			run({16'h0, a}, {16'h0, b}, cm(i[0] ? FAD_OP_HSUB : FAD_OP_HADD, 4'h0, 2'h0));
			chk(8'h10, {16'h0, s[15:0]}, 32'hFFFF);
			chk(8'h14, {s[15], s[15:0] != 0 && !s[15], s[16] != s[15]}, 32'h3F);
		end
		run(32'h5, 32'hFFFB, cm(FAD_OP_HADD, 4'h0, 2'h0));
		chk(8'h10, 32'h0, 32'hFFFF);
		chk(8'h14, 32'h0, 32'h3F);
		run(32'hFFFD, 32'h7, cm(FAD_OP_MUL, 4'h0, 2'h0));
		chk(8'h10, 32'hFFFFFFEB, 32'hFFFFFFFF);
		run(32'd100, 32'h7, cm(FAD_OP_DIV, 4'h0, 2'h0));
		chk(8'h10, 32'h0002000E, 32'hFFFFFFFF);
		m.xfer(1'b1, 8'h0C, 32'h1400);
		run(32'd100, 32'h0, cm(FAD_OP_DIV, 4'h0, 2'h0));
		chk(8'h10, 32'h0002000E, 32'hFFFFFFFF);
		chk(8'h14, 32'h08, 32'h08);
		$display("test fixed done");
		for (int o = 4; o < 7; o++) begin
			for (int w = 0; w < 3; w++) begin
				ra = $random(seed);
				rb = $random(seed);
				e = (o == 4) ? ra & rb : (o == 5) ? ra | rb : ra ^ rb;
				e &= (w == 0) ? 32'hFF : (w == 1) ? 32'hFFFF : 32'hFFFFFFFF;
				run(ra, rb, cm(fad_op_e'(o[3:0]), 4'h0, 2'(w)));
				chk(8'h10, e, 32'hFFFFFFFF);
				chk(8'h14, {30'h0, e != 0, 1'b0}, 32'h7);
			end
		end
		$display("test logical done");
		run(32'h42001234, 32'h0, cm(FAD_OP_FLOAD, 4'h2, 2'h0));
		run(32'h41200000, 32'h0, cm(FAD_OP_FLOAD, 4'hE, 2'h0));
		run(32'hC1300000, 32'h0, cm(FAD_OP_FLOAD, 4'h0, 2'h0));
		run(32'h0, 32'h0, cm(FAD_OP_FSTOR, 4'h2, 2'h0));
		chk(8'h10, 32'h40123400, 32'hFFFFFFFF);
		run(32'h0, 32'h0, cm(FAD_OP_FSTOR, 4'hE, 2'h0));
		chk(8'h10, 32'h41200000, 32'hFFFFFFFF);
		run(32'h0, 32'h0, cm(FAD_OP_FSTOR, 4'h0, 2'h0));
		chk(8'h14, 32'h04, 32'h07);
		for (int k = 0; k < 5; k++) begin
			run(fl_l[k], 32'h0, cm(FAD_OP_FLOAD, 4'h0, 2'h0));
			run(fl_a[k], 32'h0, cm(fl_o[k], 4'h0, 2'h0));
			chk(8'h10, fl_e[k], 32'hFFFFFFFF);
			chk(8'h14, fl_s[k], 32'h1F);
		end
		run(32'h0, 32'h0, cm(FAD_OP_FSTOR, 4'h0, 2'h0));
		chk(8'h10, 32'h41100000, 32'hFFFFFFFF);
		run(32'h0, 32'h0, cm(FAD_OP_FSUB, 4'h0, 2'h0) | 32'h4E00);
		chk(8'h10, 32'hC1100000, 32'hFFFFFFFF);
		run(32'h41200000, 32'h0, cm(FAD_OP_FMUL, 4'h0, 2'h0));
		chk(8'h10, 32'hC1200000, 32'hFFFFFFFF);
		run(32'h41400000, 32'h0, cm(FAD_OP_FDIV, 4'h0, 2'h0));
		chk(8'h10, 32'hC0800000, 32'hFFFFFFFF);
		chk(8'h14, 32'h04, 32'h1F);
		$display("test float done");
		tally_and_finish();
	end
endmodule
